// >>> common/timer_unit_consts.svh
`ifndef TIMER_UNIT_CONSTS_SVH
`define TIMER_UNIT_CONSTS_SVH

`define REG_PRE12      4'h0
`define REG_TIMER1     4'h1
`define REG_TIMER2     4'h2
`define REG_TIMER_X    4'h3
`define REG_TIMER_Y    4'h4
`define REG_XY_MODE    4'h5
`define REG_SRC_SEL    4'h6
`define REG_IRQ_STATUS 4'h7
`define REG_IRQ_MASK   4'h8

`define MODE_X_LSB     0
`define EDGE_X_BIT     4
`define STOP_X_BIT     6
`define SRC_PRE12_BIT  0
`define SRC_X_BIT      1

`define IRQ_X_BIT      0
`define IRQ_Y_BIT      1
`define IRQ_T1_BIT     2
`define IRQ_T2_BIT     3

`define RST_COUNT      8'hFF
`define RST_CTRL       8'h00
`define RST_IRQ        4'h0
`define DIV_SLOW_MAX   4'hF

`endif

// >>> common/timer_unit_pkg.sv
package timer_unit_pkg;
  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_PULSE = 2'b01,
    MODE_EVENT = 2'b10,
    MODE_WIDTH = 2'b11
  } timer_mode_e;
  typedef logic [7:0] byte_t;
endpackage

// >>> core/down_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_unit_consts.svh"
module down_counter (
  input  wire logic                  ref_clk,   // system clock
  input  wire logic                  rst_n,     // sync reset, low
  input  wire logic                  tick,      // count pulse
  input  wire logic                  stop,      // freeze counter
  input  wire logic                  load,      // software write
  input  wire timer_unit_pkg::byte_t wdata,     // written value
  output var  timer_unit_pkg::byte_t count,     // current count
  output logic                       underflow  // one-cycle pulse
);
  import timer_unit_pkg::*;

  byte_t latch;

  assign underflow = tick && !stop && (count == 8'h00);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      latch <= `RST_COUNT;
    end else if (load) begin
      latch <= wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count <= `RST_COUNT;
    end else if (load && stop) begin
      count <= wdata;
    end else if (underflow) begin
      count <= latch;
    end else if (tick && !stop) begin
      count <= count - 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> core/four_timer_unit.sv
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "timer_unit_consts.svh"
module four_timer_unit (
  input  wire logic                  ref_clk,             // 100 MHz clock
  input  wire logic                  rst_n,               // sync reset, low
  input  wire logic [3:0]            reg_addr,            // register address
  input  wire timer_unit_pkg::byte_t reg_wdata,           // write data
  input  wire logic                  reg_wr,              // write strobe
  input  wire logic                  reg_rd,              // read strobe
  output var  timer_unit_pkg::byte_t reg_rdata,           // read data, next cycle
  input  wire logic                  timer_x_ext_pin_in,  // x pin level
  output logic                       timer_x_ext_pin_out, // x pin drive
  output logic                       timer_x_ext_pin_oe_n,// x drive enable, low
  input  wire logic                  timer_y_ext_pin_in,  // y pin level
  output logic                       timer_y_ext_pin_out, // y pin drive
  output logic                       timer_y_ext_pin_oe_n,// y drive enable, low
  output logic [3:0]                 irq_req,             // request bits x,y,1,2
  output logic                       irq,                 // masked request level
  output logic                       osc_stop_release     // timer 1 underflow pulse
);
  import timer_unit_pkg::*;

  byte_t       xy_mode;
  byte_t       src_sel;
  logic [3:0]  irq_status;
  logic [3:0]  irq_mask;
  logic [3:0]  div_cnt;
  logic        fast_tick;
  logic        slow_tick;
  logic        pre_tick;
  logic        pre_uf;
  logic        t1_uf;
  logic        t2_uf;
  byte_t       pre_count;
  byte_t       t1_count;
  byte_t       t2_count;
  logic [1:0]  pin_in;
  logic [1:0]  pin_prev;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe_n;
  logic [1:0]  ch_tick;
  logic [1:0]  ch_uf;
  logic [1:0]  ch_stop;
  logic [1:0]  ch_load;
  byte_t       ch_count [2];
  logic [3:0]  events;
  logic [3:0]  clear_bits;
  logic [3:0]  next_status;
  byte_t       next_rdata;
  logic        xy_wr;

  // free-running divider gives both internal count sources
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  assign fast_tick = div_cnt[0];
  assign slow_tick = (div_cnt == `DIV_SLOW_MAX);

  // control registers
  assign xy_wr = reg_wr && (reg_addr == `REG_XY_MODE);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      xy_mode <= `RST_CTRL;
    end else if (reg_wr && reg_addr == `REG_XY_MODE) begin
      xy_mode <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_sel <= `RST_CTRL;
    end else if (reg_wr && reg_addr == `REG_SRC_SEL) begin
      src_sel <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_mask <= `RST_IRQ;
    end else if (reg_wr && reg_addr == `REG_IRQ_MASK) begin
      irq_mask <= reg_wdata[3:0];
    end
  end

  // shared prescaler feeding timers 1 and 2
  assign pre_tick = src_sel[`SRC_PRE12_BIT] ? slow_tick : fast_tick;

  down_counter u_pre12 (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .tick      (pre_tick),
    .stop      (1'b0),
    .load      (reg_wr && reg_addr == `REG_PRE12),
    .wdata     (reg_wdata),
    .count     (pre_count),
    .underflow (pre_uf)
  );

  down_counter u_timer1 (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .tick      (pre_uf),
    .stop      (1'b0),
    .load      (reg_wr && reg_addr == `REG_TIMER1),
    .wdata     (reg_wdata),
    .count     (t1_count),
    .underflow (t1_uf)
  );

  down_counter u_timer2 (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .tick      (pre_uf),
    .stop      (1'b0),
    .load      (reg_wr && reg_addr == `REG_TIMER2),
    .wdata     (reg_wdata),
    .count     (t2_count),
    .underflow (t2_uf)
  );

  // timers x and y share one structure, index 0 is x
  assign pin_in = {timer_y_ext_pin_in, timer_x_ext_pin_in};

  // previous pin level for edge detection; pins arrive synchronous
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_prev <= 2'b00;
    end else begin
      pin_prev <= pin_in;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_xy
      timer_mode_e mode;
      logic        edge_sel;
      logic        src_tick;
      logic        rise;
      logic        fall;
      logic        new_edge;

      assign new_edge = reg_wdata[`EDGE_X_BIT + i];
      assign mode     = timer_mode_e'(xy_mode[`MODE_X_LSB + 2*i +: 2]);
      assign edge_sel = xy_mode[`EDGE_X_BIT + i];
      assign src_tick = src_sel[`SRC_X_BIT + i] ? slow_tick : fast_tick;
      assign rise     = pin_in[i] && !pin_prev[i];
      assign fall     = !pin_in[i] && pin_prev[i];
      assign ch_stop[i] = xy_mode[`STOP_X_BIT + i];
      assign ch_load[i] = reg_wr && (reg_addr == (`REG_TIMER_X + 4'(i)));

      always_comb begin
        case (mode)
          MODE_TIMER: ch_tick[i] = src_tick;
          MODE_PULSE: ch_tick[i] = src_tick;
          MODE_EVENT: ch_tick[i] = edge_sel ? fall : rise;
          MODE_WIDTH: ch_tick[i] = src_tick && (pin_in[i] != edge_sel);
          default:    ch_tick[i] = 1'b0;
        endcase
      end

      down_counter u_chan (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .tick      (ch_tick[i]),
        .stop      (ch_stop[i]),
        .load      (ch_load[i]),
        .wdata     (reg_wdata),
        .count     (ch_count[i]),
        .underflow (ch_uf[i])
      );

      // a write entering pulse mode or flipping the edge presets the start level,
      // so mode and edge may be written together in one go
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          pin_out[i] <= 1'b1;
        end else if (xy_wr && (mode != MODE_PULSE || new_edge != edge_sel)) begin
          pin_out[i] <= !new_edge;
        end else if (mode != MODE_PULSE) begin
          pin_out[i] <= !edge_sel;
        end else if (ch_uf[i]) begin
          pin_out[i] <= !pin_out[i];
        end
      end

      // port direction stays software's job; this only enables the driver
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          pin_oe_n[i] <= 1'b1;
        end else begin
          pin_oe_n[i] <= (mode != MODE_PULSE);
        end
      end
    end
  endgenerate

  assign timer_x_ext_pin_out  = pin_out[0];
  assign timer_y_ext_pin_out  = pin_out[1];
  assign timer_x_ext_pin_oe_n = pin_oe_n[0];
  assign timer_y_ext_pin_oe_n = pin_oe_n[1];

  // request bits: hardware sets, software writes one to clear
  always_comb begin
    events = 4'h0;
    events[`IRQ_X_BIT]  = ch_uf[0];
    events[`IRQ_Y_BIT]  = ch_uf[1];
    events[`IRQ_T1_BIT] = t1_uf;
    events[`IRQ_T2_BIT] = t2_uf;
  end

  assign clear_bits = (reg_wr && reg_addr == `REG_IRQ_STATUS) ? reg_wdata[3:0] : 4'h0;
  // set wins over a clear in the same cycle; a write never sets
  assign next_status = (irq_status & ~clear_bits) | events;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_status <= `RST_IRQ;
    end else begin
      irq_status <= next_status;
    end
  end

  assign irq_req = irq_status;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & irq_mask);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      osc_stop_release <= 1'b0;
    end else begin
      osc_stop_release <= t1_uf;
    end
  end

  // read path; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      `REG_PRE12:      next_rdata = pre_count;
      `REG_TIMER1:     next_rdata = t1_count;
      `REG_TIMER2:     next_rdata = t2_count;
      `REG_TIMER_X:    next_rdata = ch_count[0];
      `REG_TIMER_Y:    next_rdata = ch_count[1];
      `REG_XY_MODE:    next_rdata = xy_mode;
      `REG_SRC_SEL:    next_rdata = src_sel;
      `REG_IRQ_STATUS: next_rdata = {4'h0, irq_status};
      `REG_IRQ_MASK:   next_rdata = {4'h0, irq_mask};
      default:         next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// >>> verif/timer_unit_properties.sv
`timescale 1ns/10ps
`default_nettype none
module timer_unit_checker (
  input wire logic                  ref_clk,              // clock
  input wire logic                  rst_n,                // sync reset
  input wire logic [3:0]            reg_addr,             // address
  input wire timer_unit_pkg::byte_t reg_wdata,            // write data
  input wire logic                  reg_wr,               // write strobe
  input wire logic                  timer_x_ext_pin_out,  // x drive
  input wire logic                  timer_x_ext_pin_oe_n, // x enable
  input wire logic                  timer_y_ext_pin_out,  // y drive
  input wire logic                  timer_y_ext_pin_oe_n, // y enable
  input wire logic [3:0]            irq_req,              // requests
  input wire logic                  irq,                  // level
  input wire logic                  osc_stop_release      // release pulse
);
  import timer_unit_pkg::*;
  // shadows of the write-only view of mode and mask
  byte_t      mode_sh;
  logic [3:0] mask_sh;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_sh <= 8'h00;
      mask_sh <= 4'h0;
    end else if (reg_wr && reg_addr == 4'h5) begin
      mode_sh <= reg_wdata;
    end else if (reg_wr && reg_addr == 4'h8) begin
      mask_sh <= reg_wdata[3:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // three cycles lets an underflow already in flight land first
  sequence s_x_held; mode_sh[6] [*3]; endsequence
  sequence s_y_held; mode_sh[7] [*3]; endsequence
  property p_x_frozen; s_x_held |-> !$rose(irq_req[0]); endproperty
  property p_y_frozen; s_y_held |-> !$rose(irq_req[1]); endproperty
  property p_x_oe;
    mode_sh[1:0] == $past(mode_sh[1:0]) |-> timer_x_ext_pin_oe_n == (mode_sh[1:0] != MODE_PULSE);
  endproperty
  property p_y_oe;
    mode_sh[3:2] == $past(mode_sh[3:2]) |-> timer_y_ext_pin_oe_n == (mode_sh[3:2] != MODE_PULSE);
  endproperty
  property p_x_start; $fell(timer_x_ext_pin_oe_n) |-> timer_x_ext_pin_out == !mode_sh[4]; endproperty
  property p_y_start; $fell(timer_y_ext_pin_oe_n) |-> timer_y_ext_pin_out == !mode_sh[5]; endproperty
  property p_irq;
    mask_sh == $past(mask_sh) && mask_sh == $past(mask_sh, 2) |-> irq == |(irq_req & mask_sh);
  endproperty
  property p_release; osc_stop_release |-> irq_req[2]; endproperty
  a_x_frozen: assert property (p_x_frozen) else $error("x request rose while stopped");
  a_y_frozen: assert property (p_y_frozen) else $error("y request rose while stopped");
  a_x_oe: assert property (p_x_oe) else $error("x drive enable wrong for mode");
  a_y_oe: assert property (p_y_oe) else $error("y drive enable wrong for mode");
  a_x_start: assert property (p_x_start) else $error("x pulse start level wrong");
  a_y_start: assert property (p_y_start) else $error("y pulse start level wrong");
  a_irq: assert property (p_irq) else $error("irq not equal to masked requests");
  a_release: assert property (p_release) else $error("release without timer 1 request");
endmodule
bind four_timer_unit timer_unit_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .timer_x_ext_pin_out(timer_x_ext_pin_out), .timer_x_ext_pin_oe_n(timer_x_ext_pin_oe_n),
  .timer_y_ext_pin_out(timer_y_ext_pin_out), .timer_y_ext_pin_oe_n(timer_y_ext_pin_oe_n),
  .irq_req(irq_req), .irq(irq), .osc_stop_release(osc_stop_release));
`default_nettype wire

// >>> verif/pin_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  input  wire logic drv,      // unit drive level
  input  wire logic drv_oe_n, // unit enable, low
  input  wire logic ext,      // far-side level
  output logic      pin       // resolved wire
);
  // port set to output only while the unit drives, else far side owns it
  assign pin = drv_oe_n ? ext : drv;
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import timer_unit_pkg::*;
  logic       ref_clk;
  logic       rst_n;
  logic [3:0] reg_addr;
  byte_t      reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  byte_t      reg_rdata;
  logic       x_in, x_out, x_oe_n, ext_x;
  logic       y_in, y_out, y_oe_n, ext_y;
  logic [3:0] irq_req;
  logic       irq, osc, osc_seen;
  int         errors = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  four_timer_unit u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_x_ext_pin_in(x_in), .timer_x_ext_pin_out(x_out),
    .timer_x_ext_pin_oe_n(x_oe_n), .timer_y_ext_pin_in(y_in), .timer_y_ext_pin_out(y_out),
    .timer_y_ext_pin_oe_n(y_oe_n), .irq_req(irq_req), .irq(irq), .osc_stop_release(osc));
  pin_partner u_px (.drv(x_out), .drv_oe_n(x_oe_n), .ext(ext_x), .pin(x_in));
  pin_partner u_py (.drv(y_out), .drv_oe_n(y_oe_n), .ext(ext_y), .pin(y_in));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (osc === 1'b1) osc_seen = 1'b1;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize;
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input byte_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output byte_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input byte_t e);
    byte_t d;
    rd(a, d);
    chk(n, d, e);
  endtask
  task automatic clr(input int b);
    wr(4'h7, byte_t'(8'h01 << b));
  endtask
  task automatic wset(input int b, output int t);
    int n;
    n = 0;
    #1;
    while (irq_req[b] !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 2000) errors++;
    t = cyc;
  endtask
  // interval between two request sets, taken after a full reload
  task automatic per(input int b, output int p);
    int t0;
    int t1;
    clr(b);
    wset(b, t0);
    clr(b);
    wset(b, t1);
    p = t1 - t0;
  endtask
  task automatic t_reset;
    rchk("x count", 4'h3, 8'hFF);
    rchk("mode", 4'h5, 8'h00);
    rchk("unmapped", 4'hA, 8'h00);
  endtask
  task automatic t_timer;
    byte_t c1;
    byte_t c2;
    int    p;
    wr(4'h5, 8'h40);
    wr(4'h3, 8'hF0);
    rchk("x load", 4'h3, 8'hF0);
    wr(4'h5, 8'h00);
    rd(4'h3, c1);
    rd(4'h3, c2);
    chk("x step", c1 - c2, 16'h1);
    per(0, p);
    chk("x period", p[15:0], 16'h1E2);
  endtask
  task automatic t_pulse;
    int t;
    for (int i = 0; i < 2; i++) begin
      wr(4'h5, 8'hC5 | {2'b00, i[0], i[0], 4'h0});
      wr(4'h3, 8'h02);
      @(posedge ref_clk);
      #1 chk("x oe", x_oe_n, 1'b0);
      chk("y oe", y_oe_n, 1'b0);
      chk("x start", x_out, !i[0]);
      chk("y start", y_out, !i[0]);
      wr(4'h5, 8'h85 | {2'b00, i[0], i[0], 4'h0});
      clr(0);
      wset(0, t);
      repeat (2) @(posedge ref_clk);
      #1 chk("x toggled", x_out, i[0]);
    end
    wr(4'h5, 8'h40);
  endtask
  task automatic pin_x(input logic v);
    @(posedge ref_clk);
    ext_x <= v;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic t_event;
    for (int i = 0; i < 2; i++) begin
      ext_x <= i[0];
      wr(4'h5, 8'h42 | {3'b000, i[0], 4'h0});
      wr(4'h3, 8'h01);
      wr(4'h5, 8'h02 | {3'b000, i[0], 4'h0});
      clr(0);
      pin_x(!i[0]);
      rchk("x active", 4'h3, 8'h00);
      pin_x(i[0]);
      rchk("x idle", 4'h3, 8'h00);
      pin_x(!i[0]);
      chk("x event uf", irq_req[0], 1'b1);
    end
  endtask
  task automatic t_width;
    byte_t c1;
    byte_t c2;
    for (int i = 0; i < 2; i++) begin
      ext_y <= i[0];
      wr(4'h5, 8'h8C | {2'b00, i[0], 5'h00});
      wr(4'h4, 8'hFF);
      wr(4'h5, 8'h0C | {2'b00, i[0], 5'h00});
      repeat (20) @(posedge ref_clk);
      rchk("y held", 4'h4, 8'hFF);
      ext_y <= !i[0];
      repeat (20) @(posedge ref_clk);
      wr(4'h5, 8'h8C);
      rd(4'h4, c1);
      chk("y counted", c1 == 8'hFF, 1'b0);
      repeat (10) @(posedge ref_clk);
      rd(4'h4, c2);
      chk("y stopped", c2, c1);
    end
  endtask
  task automatic t_irq;
    int t;
    wr(4'h5, 8'h40);
    clr(0);
    wr(4'h7, 8'h01);
    #1 chk("no sw set", irq_req[0], 1'b0);
    wr(4'h3, 8'h03);
    wr(4'h8, 8'h01);
    wr(4'h5, 8'h00);
    wset(0, t);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq on", irq, 1'b1);
    wr(4'h8, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq masked", irq, 1'b0);
    wr(4'h5, 8'h40);
    clr(0);
    #1 chk("cleared", irq_req[0], 1'b0);
  endtask
  task automatic t_pair;
    int p;
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h03);
    wr(4'h2, 8'h02);
    per(2, p);
    chk("t1 period", p[15:0], 16'h8);
    per(3, p);
    chk("t2 period", p[15:0], 16'h6);
    wr(4'h6, 8'h01);
    wr(4'h0, 8'h00);
    per(2, p);
    chk("t1 slow", p[15:0], 16'h40);
    chk("release", osc_seen, 1'b1);
  endtask
  initial begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_x = 1'b0;
    ext_y = 1'b0;
    osc_seen = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_timer();
    t_pulse();
    t_event();
    t_width();
    t_irq();
    t_pair();
    summarize();
  end
endmodule
`default_nettype wire
